// ---- logic/csc_cfg.svh ----
// Purpose: Register offsets, field positions, reset values and codes of the clock select control.
// Assumes: 32-bit Avalon-MM word addressing by byte address, one register per aligned word.
// Notes:   Definitions only.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define CSC_ADDR_W          4
`define CSC_OFS_SYSCLK      4'h0
`define CSC_OFS_LOWPWR      4'h4
`define CSC_OFS_MODE        4'h8
`define CSC_OFS_STATUS      4'hC
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CSC_RST_SYSCLK      8'h00
`define CSC_RST_LOWPWR      8'h00
`define CSC_SYSCLK_WMASK    8'hC7
`define CSC_BIT_OUT_DIS     7
`define CSC_BIT_BYPASS      5
`define CSC_SEL_FULL        3'h0
`define CSC_SEL_MAX         3'h5
`define CSC_DIV_W           5
// Duty correction threshold in kHz, and the bit width of the oscillator rate in kHz reported by the clock source.
`define CSC_DUTY_MIN_KHZ    20'h01388
`define CSC_FREQ_W          20
`endif

// ---- logic/csc_pkg.sv ----
// Purpose: Types shared by the clock select control files.
// Assumes: csc_cfg.svh holds the numbers.
// Notes:   Mode is one-hot.
`include "csc_cfg.svh"
package csc_pkg;
  // Power mode of the device as seen by this block.
  typedef enum logic [3:0] {
    CSC_MODE_RUN   = 4'h1,
    CSC_MODE_SLEEP = 4'h2,
    CSC_MODE_SSBY  = 4'h4,
    CSC_MODE_HSBY  = 4'h8
  } csc_mode_t;
  // Clock output pin signals.
  typedef struct packed {
    logic o;
    logic oe;
  } csc_pin_t;
endpackage

// ---- logic/csc_divider.sv ----
// Purpose: Medium-speed divider producing one-cycle enables for phi/2 to phi/32.
// Assumes: Runs on the system clock.
// Notes:   Select codes above the legal range are treated as full speed.
`include "csc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_divider
  import csc_pkg::*;
#(
  parameter int DIV_W = `CSC_DIV_W
) (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic [2:0] select_in,
  output logic            tick_out
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } csc_div_state_t;
  csc_div_state_t state_ff;
  csc_div_state_t nxt_state;
  logic [DIV_W-1:0] mask;  // Low counter bits that must all be one for a tick.

  // Builds the all-ones mask for a divide by two to the select power.
  function automatic logic [DIV_W-1:0] csc_mask(input logic [2:0] sel);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Free counter; a tick marks the last phi cycle of each divided period.
  always_comb begin
    mask = csc_mask(select_in);
    nxt_state = state_ff;
    nxt_state.cnt = state_ff.cnt + 1'b1;
    if (select_in == `CSC_SEL_FULL || select_in > `CSC_SEL_MAX) begin
      nxt_state.tick = 1'b1;  // Full speed: every cycle.
    end else begin
      nxt_state.tick = ((state_ff.cnt + 1'b1) & mask) == mask;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick_out = state_ff.tick;
endmodule
`default_nettype wire

// ---- logic/csc_sync.sv ----
// Purpose: Two flip-flop synchroniser for a bus of pin levels.
// Assumes: Inputs are quasi-static levels.
// Notes:   First stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module csc_sync
  import csc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csc_sync_state_t;
  csc_sync_state_t state_ff;
  csc_sync_state_t nxt_state;

  // Shift the pin level through two stages.
  always_comb begin
    nxt_state.s1 = d_in;
    nxt_state.s2 = state_ff.s1;
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign q_out = state_ff.s2;
endmodule
`default_nettype wire

// ---- logic/csc_top.sv ----
// Purpose: Clock select and low power control registers over Avalon-MM.
// Assumes: 100 MHz clock_in; mode and oscillator rate come from pins.
// Notes:   Waitrequest drops one cycle after a request; read data lands then.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`include "csc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_top
  import csc_pkg::*;
(
  input  wire logic                     clock_in,
  input  wire logic                     resetn_in,
  input  wire logic [`CSC_ADDR_W-1:0]   avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic      [31:0]              avs_readdata_out,
  output logic                          avs_waitrequest_out,
  output logic      [1:0]               avs_response_out,
  input  wire logic                     sleep_req_in,
  input  wire logic                     soft_standby_in,
  input  wire logic                     hard_standby_in,
  input  wire logic [`CSC_FREQ_W-1:0]   osc_freq_khz_in,
  output logic                          clock_pin_out,
  output logic                          clock_pin_oe_out,
  output logic                          bus_clock_tick_out,
  output logic                          feedback_resistor_bypass_out,
  output logic                          duty_adjust_enable_out
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  sysclk;       // System clock control register.
    logic [7:0]  lowpwr;       // Low power control register.
    logic        bypass_live;  // Bypass selection applied to the oscillator.
    csc_mode_t   mode;         // Current power mode.
    logic        ack;          // Answer phase of a bus access.
    logic [31:0] rdata;        // Read data.
    logic [1:0]  resp;         // Avalon response code.
    csc_pin_t    pin;          // Clock pin drive.
    logic        tick;         // Registered bus master clock enable.
    logic        duty_en;      // Duty correction in use.
  } csc_state_t;
  csc_state_t state_ff;
  csc_state_t nxt_state;

  logic [2:0]               mode_sync;  // Synchronised sleep, soft and hard standby pins.
  logic [`CSC_FREQ_W-1:0]   freq_sync;  // Synchronised oscillator rate.
  logic                     div_tick;   // Divider enable.
  logic                     req;        // Request in its first cycle.
  logic [7:0]               wbyte;      // Written low byte.

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Mode pins come from outside the clock domain, so two stages each.
  csc_sync #(.W(3)) u_mode_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .d_in      ({hard_standby_in, soft_standby_in, sleep_req_in}),
    .q_out     (mode_sync)
  );
  // The rate is quasi-static; it only steers duty correction.
  csc_sync #(.W(`CSC_FREQ_W)) u_freq_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .d_in      (osc_freq_khz_in),
    .q_out     (freq_sync)
  );

  // ****************************************************************
  // Medium-speed divider
  // ****************************************************************
  csc_divider #(.DIV_W(`CSC_DIV_W)) u_div (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .select_in (state_ff.sysclk[2:0]),
    .tick_out  (div_tick)
  );

  // Returns the power mode from the synchronised pins; hardware standby wins.
  function automatic csc_mode_t csc_decode_mode(input logic [2:0] p);
    csc_mode_t m;
    m = CSC_MODE_RUN;
    if (p[2]) begin
      m = CSC_MODE_HSBY;
    end else if (p[1]) begin
      m = CSC_MODE_SSBY;
    end else if (p[0]) begin
      m = CSC_MODE_SLEEP;
    end
    return m;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Requests are taken once; the ack cycle drops waitrequest and blocks a retake.
  always_comb begin
    req = (avs_read_in || avs_write_in) && !state_ff.ack;
    wbyte = avs_writedata_in[7:0];
    nxt_state = state_ff;
    nxt_state.mode = csc_decode_mode(mode_sync);
    nxt_state.ack = req;
    nxt_state.tick = div_tick;
    if (req) begin
      nxt_state.rdata = '0;
      nxt_state.resp = 2'h0;
      if (avs_address_in == `CSC_OFS_SYSCLK) begin
        nxt_state.rdata[7:0] = state_ff.sysclk;  // Reserved bits 5..3 are never stored.
        if (avs_write_in && avs_byteenable_in[0]) begin
          // Bit 6 stores what software writes; software keeps it zero.
          nxt_state.sysclk = wbyte & `CSC_SYSCLK_WMASK;
        end
      end else if (avs_address_in == `CSC_OFS_LOWPWR) begin
        nxt_state.rdata[7:0] = state_ff.lowpwr;
        if (avs_write_in && avs_byteenable_in[0]) begin
          nxt_state.lowpwr = wbyte;  // All eight bits store; only bit 5 acts.
        end
      end else if (avs_address_in == `CSC_OFS_MODE) begin
        nxt_state.rdata[3:0] = state_ff.mode;
      end else if (avs_address_in == `CSC_OFS_STATUS) begin
        nxt_state.rdata[1:0] = {state_ff.duty_en, state_ff.bypass_live};
      end else begin
        nxt_state.resp = 2'h2;  // Unmapped address: slave error, reads zero.
      end
    end
    // Bypass choice moves to the oscillator only on entry to software standby.
    if (nxt_state.mode == CSC_MODE_SSBY && state_ff.mode != CSC_MODE_SSBY) begin
      nxt_state.bypass_live = state_ff.lowpwr[`CSC_BIT_BYPASS];
    end
    // Duty correction needs no bypass and a fast enough oscillator.
    nxt_state.duty_en = !state_ff.bypass_live && (freq_sync >= `CSC_DUTY_MIN_KHZ);
    // Clock pin: toggles every cycle while enabled in run and sleep, a high level when disabled or in software standby.
    case (nxt_state.mode)
      CSC_MODE_HSBY: begin
        nxt_state.pin = '{o: 1'b0, oe: 1'b0};  // Floats.
      end
      CSC_MODE_SSBY: begin
        nxt_state.pin = '{o: 1'b1, oe: 1'b1};
      end
      default: begin
        nxt_state.pin = '{o: ~state_ff.sysclk[`CSC_BIT_OUT_DIS] ? ~state_ff.pin.o | state_ff.sysclk[7] : 1'b1,
                          oe: 1'b1};
      end
    endcase
    // Hardware standby clears both registers like a reset.
    if (nxt_state.mode == CSC_MODE_HSBY) begin
      nxt_state.sysclk = `CSC_RST_SYSCLK;
      nxt_state.lowpwr = `CSC_RST_LOWPWR;
      nxt_state.bypass_live = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '{sysclk: `CSC_RST_SYSCLK, lowpwr: `CSC_RST_LOWPWR, bypass_live: 1'b0,
                    mode: CSC_MODE_RUN, ack: 1'b0, rdata: 32'h0, resp: 2'h0,
                    pin: '{o: 1'b1, oe: 1'b1}, tick: 1'b0, duty_en: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign avs_readdata_out             = state_ff.rdata;
  assign avs_waitrequest_out          = ~state_ff.ack;
  assign avs_response_out             = state_ff.resp;
  assign clock_pin_out                = state_ff.pin.o;
  assign clock_pin_oe_out             = state_ff.pin.oe;
  assign bus_clock_tick_out           = state_ff.tick;
  assign feedback_resistor_bypass_out = state_ff.bypass_live;
  assign duty_adjust_enable_out       = state_ff.duty_en;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_SYSCLK_RESERVED: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.sysclk[5:3] == 3'h0) else $error("reserved clock control bits not zero");
  AST_HSBY_CLEAR: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.mode == CSC_MODE_HSBY |-> state_ff.sysclk == 8'h00 && state_ff.lowpwr == 8'h00)
    else $error("registers not cleared in hardware standby");
  AST_SSBY_KEEP: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.mode == CSC_MODE_SSBY && !avs_write_in && nxt_state.mode != CSC_MODE_HSBY
      |=> $stable(state_ff.lowpwr))
    else $error("low power register changed in software standby");
  AST_PIN_SSBY: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.mode == CSC_MODE_SSBY |-> ##1 (clock_pin_out && clock_pin_oe_out) || nxt_state.mode != CSC_MODE_SSBY)
    else $error("clock pin not high in software standby");
  AST_PIN_HSBY: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.mode == CSC_MODE_HSBY && $past(nxt_state.mode) == CSC_MODE_HSBY |-> !clock_pin_oe_out)
    else $error("clock pin driven in hardware standby");
  AST_PIN_DISABLED: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.sysclk[7] && nxt_state.mode == CSC_MODE_RUN |=> clock_pin_out)
    else $error("disabled clock pin toggled");
  AST_BYPASS_ENTRY: assert property (@(posedge clock_in) disable iff (!resetn_in)
    $changed(state_ff.bypass_live) && state_ff.mode != CSC_MODE_HSBY |-> state_ff.mode == CSC_MODE_SSBY
      && $past(state_ff.mode) != CSC_MODE_SSBY) else $error("bypass changed outside standby entry");
  AST_DUTY_SLOW: assert property (@(posedge clock_in) disable iff (!resetn_in)
    freq_sync < `CSC_DUTY_MIN_KHZ ##1 $stable(freq_sync) |-> !state_ff.duty_en)
    else $error("duty correction on below threshold");
  AST_FULL_SPEED: assert property (@(posedge clock_in) disable iff (!resetn_in)
    state_ff.sysclk[2:0] == 3'h0 [*3] |-> bus_clock_tick_out) else $error("full speed tick missing");
  // Helper for the divide by 32 check: cycles since the last tick, and ticks seen under one select.
  // The tick lags a select change by two registers, so the first two ticks after a change are not trusted.
  logic [5:0] gap_cnt_ff;    // Tickless cycles between the last bus clock tick and this cycle.
  logic [1:0] gap_ticks_ff;  // Ticks seen since the select last changed, saturating.
  logic [2:0] gap_sel_ff;    // Select code of the previous cycle.

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_cnt_ff   <= 6'h00;
      gap_ticks_ff <= 2'h0;
      gap_sel_ff   <= 3'h0;
    end else begin
      gap_cnt_ff <= bus_clock_tick_out ? 6'h00 : gap_cnt_ff + 6'h01;
      gap_sel_ff <= state_ff.sysclk[2:0];
      if (state_ff.sysclk[2:0] != gap_sel_ff) begin
        gap_ticks_ff <= 2'h0;
      end else if (bus_clock_tick_out && gap_ticks_ff != 2'h3) begin
        gap_ticks_ff <= gap_ticks_ff + 2'h1;
      end
    end
  end

  AST_DIV32: assert property (@(posedge clock_in) disable iff (!resetn_in)
    bus_clock_tick_out && gap_ticks_ff >= 2'h2 && state_ff.sysclk[2:0] == 3'h5
      && gap_sel_ff == 3'h5 |-> gap_cnt_ff == 6'h1F) else $error("divide by 32 spacing wrong");
endmodule
`default_nettype wire

// ---- bench/csc_clk_source.sv ----
// Purpose: Model of the external clock source that feeds the oscillator rate pin.
// Assumes: The rate is reported in kHz as a level.
// Notes:   A requested rate is only taken while the software standby pin is high.
`include "csc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_clk_source
  import csc_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   resetn_in,
  input  wire logic                   soft_standby_in,
  input  wire logic [`CSC_FREQ_W-1:0] want_khz_in,
  output logic      [`CSC_FREQ_W-1:0] osc_freq_khz_out
);
  // Switching while running would glitch the core clock, so the source waits for standby.
  // The source is an external clock, never a crystal, so software may touch the bypass bit.
  // Only the rate level is modelled; the source's clock itself is taken as held high in standby.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_freq_khz_out <= 20'h01F40;
    end else if (soft_standby_in) begin
      osc_freq_khz_out <= want_khz_in;
    end
  end
endmodule
`default_nettype wire

// ---- bench/csc_top_test.sv ----
// Purpose: Self-checking bench of the clock select control registers and outputs.
// Assumes: Waitrequest drops one cycle after a request is taken.
// Notes:   Ordinary register cases are rows of a table; mode cases are written out.
`include "csc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module csc_top_test;
  import csc_pkg::*;
  // One table row: address, written byte, expected readback, expected response.
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
  } csc_row_t;
  logic        clock_in, resetn_in, rd, wr, sleep, ssby, hsby;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  resp, r;
  logic [19:0] want, freq;
  logic        wait_n, pin, pin_oe, tick, byp, duty, p0;
  int          num_errors, comparisons, cycles, n;
  csc_row_t    rows [5];
  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  initial clock_in = 1'b0;
  always #5 clock_in = ~clock_in;
  csc_top csc_top_inst (.clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_n), .avs_response_out(resp),
    .sleep_req_in(sleep), .soft_standby_in(ssby), .hard_standby_in(hsby),
    .osc_freq_khz_in(freq), .clock_pin_out(pin), .clock_pin_oe_out(pin_oe),
    .bus_clock_tick_out(tick), .feedback_resistor_bypass_out(byp), .duty_adjust_enable_out(duty));
  csc_clk_source csc_clk_source_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .soft_standby_in(ssby), .want_khz_in(want), .osc_freq_khz_out(freq));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Compares one value with case equality so an unknown never matches.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One Avalon transfer; the request is held until waitrequest is sampled low at a rising edge,
  // where the answer is taken and the request released.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] dq, output logic [1:0] dr);
    @(posedge clock_in);
    addr  <= a;
    wdata <= {24'h000000, d};
    wr    <= w;
    rd    <= ~w;
    do @(posedge clock_in); while (wait_n !== 1'b0);
    dq = rdata;
    dr = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Sets the three mode levels and lets the synchroniser settle.
  task automatic mode(input logic s, input logic sb, input logic hb);
    @(posedge clock_in);
    sleep <= s;
    ssby  <= sb;
    hsby  <= hb;
    repeat (6) @(negedge clock_in);
  endtask
  // Counts bus clock ticks over 64 cycles, which every divide ratio fills exactly.
  task automatic count_ticks(output int c);
    c = 0;
    repeat (40) @(negedge clock_in);
    repeat (64) begin
      @(negedge clock_in);
      c += tick;
    end
  endtask
  // A hang ends the run as a mismatch.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rd, wr, sleep, ssby, hsby} = 5'h00;
    addr = 4'h0;
    be = 4'hF;
    wdata = 32'h00000000;
    want = 20'h01F40;
    resetn_in = 1'b0;
    rows[0] = '{4'h0, 8'h3D, 8'h05, 2'h0};
    rows[1] = '{4'h0, 8'h80, 8'h80, 2'h0};
    rows[2] = '{4'h4, 8'hDF, 8'hDF, 2'h0};
    rows[3] = '{4'h4, 8'h00, 8'h00, 2'h0};
    rows[4] = '{4'h1, 8'h55, 8'h00, 2'h2};
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    bus(1'b0, 4'h0, 8'h00, q, r);
    check("sysclk reset", 32'h00000000, q);
    bus(1'b0, 4'h4, 8'h00, q, r);
    check("lowpwr reset", 32'h00000000, q);
    // Table rows: write, then read back with reserved bits masked.
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, q, r);
      check("write resp", {30'h0, rows[i].r}, {30'h0, r});
      bus(1'b0, rows[i].a, 8'h00, q, r);
      check("read resp", {30'h0, rows[i].r}, {30'h0, r});
      if (rows[i].r == 2'h0) begin
        check("readback", {24'h0, rows[i].q}, q);
      end
    end
    // Every legal select code divides the tick rate by its power of two.
    for (int c = 0; c < 6; c++) begin
      bus(1'b1, 4'h0, 8'(c), q, r);
      count_ticks(n);
      check("ticks", 32'(64 >> c), 32'(n));
    end
    // Pin follows the clock in sleep, held high when disabled; software standby is checked below.
    bus(1'b1, 4'h0, 8'h00, q, r);
    mode(1'b1, 1'b0, 1'b0);
    p0 = pin;
    @(negedge clock_in);
    check("pin toggles", {31'h0, ~p0}, {31'h0, pin});
    bus(1'b1, 4'h0, 8'h80, q, r);
    repeat (4) @(negedge clock_in);
    check("pin disabled", 32'h3, {30'h0, pin_oe, pin});
    bus(1'b1, 4'h0, 8'h00, q, r);
    // Bypass written in run is not applied until software standby is entered.
    mode(1'b0, 1'b0, 1'b0);
    bus(1'b1, 4'h4, 8'h20, q, r);
    repeat (4) @(negedge clock_in);
    check("bypass early", 32'h1, {30'h0, byp, duty});
    want <= 20'h00FA0;
    mode(1'b0, 1'b1, 1'b0);
    check("ssby pin", 32'h3, {30'h0, pin_oe, pin});
    check("bypass applied", 32'h2, {30'h0, byp, duty});
    bus(1'b0, 4'h8, 8'h00, q, r);
    check("mode reg", 32'h4, q);
    bus(1'b0, 4'h0, 8'h00, q, r);
    check("sysclk kept", 32'h0, q);
    bus(1'b0, 4'h4, 8'h00, q, r);
    check("lowpwr kept", 32'h20, q);
    // Duty correction at the 5000 kHz boundary and below it, with no bypass.
    bus(1'b1, 4'h4, 8'h00, q, r);
    mode(1'b0, 1'b0, 1'b0);
    mode(1'b0, 1'b1, 1'b0);
    check("duty 4000", 32'h0, {30'h0, byp, duty});
    want <= 20'h01388;
    mode(1'b0, 1'b0, 1'b0);
    mode(1'b0, 1'b1, 1'b0);
    check("duty 5000", 32'h1, {30'h0, byp, duty});
    // A write without lane 0 is ignored.
    mode(1'b0, 1'b0, 1'b0);
    be <= 4'hE;
    bus(1'b1, 4'h4, 8'hFF, q, r);
    be <= 4'hF;
    bus(1'b0, 4'h4, 8'h00, q, r);
    check("lane0 off", 32'h0, q);
    // Hardware standby floats the pin and clears both registers.
    bus(1'b1, 4'h0, 8'h85, q, r);
    bus(1'b1, 4'h4, 8'hC1, q, r);
    mode(1'b0, 1'b0, 1'b1);
    check("hsby pin", 32'h0, {31'h0, pin_oe});
    mode(1'b0, 1'b0, 1'b0);
    bus(1'b0, 4'h0, 8'h00, q, r);
    check("sysclk hsby", 32'h0, q);
    bus(1'b0, 4'h4, 8'h00, q, r);
    check("lowpwr hsby", 32'h0, q);
    wrap_up();
  end
endmodule
`default_nettype wire
